// ===== cmpr_pkg.sv
package cmpr_pkg;

   // ************************************************************
   // widths and register count
   // ************************************************************
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned NUM_GPR   = 13;
   localparam int unsigned EXC_W     = 6;

   // ************************************************************
   // register numbers on the core register port
   // ************************************************************
   localparam logic [3:0] REG_SP = 4'hd;
   localparam logic [3:0] REG_LR = 4'he;
   localparam logic [3:0] REG_PC = 4'hf;

   // ************************************************************
   // special register selectors for the move instructions
   // ************************************************************
   localparam logic [3:0] SPR_FLAGS       = 4'h0;
   localparam logic [3:0] SPR_FLAGS_EXC   = 4'h1;
   localparam logic [3:0] SPR_FLAGS_EXEC  = 4'h2;
   localparam logic [3:0] SPR_PSW         = 4'h3;
   localparam logic [3:0] SPR_EXC         = 4'h5;
   localparam logic [3:0] SPR_EXEC        = 4'h6;
   localparam logic [3:0] SPR_EXEC_EXC    = 4'h7;
   localparam logic [3:0] SPR_MAIN_SP     = 4'h8;
   localparam logic [3:0] SPR_PROC_SP     = 4'h9;
   localparam logic [3:0] SPR_PRIO_MASK   = 4'ha;
   localparam logic [3:0] SPR_MODE_CTRL   = 4'hb;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int unsigned FLAG_N_BIT     = 31;
   localparam int unsigned FLAG_V_BIT     = 28;
   localparam int unsigned EXEC_T_BIT     = 24;
   localparam int unsigned CTRL_PRIV_BIT  = 0;
   localparam int unsigned CTRL_STACK_BIT = 1;
   localparam int unsigned PMASK_BIT      = 0;

   // ************************************************************
   // reset values, vector addresses and stack step
   // ************************************************************
   localparam logic [5:0]  EXC_RESET    = 6'h00;
   localparam logic [1:0]  CTRL_RESET   = 2'h0;
   localparam logic        PMASK_RESET  = 1'b0;
   localparam logic [31:0] VEC_SP_ADDR  = 32'h0000_0000;
   localparam logic [31:0] VEC_PC_ADDR  = 32'h0000_0004;
   localparam logic [31:0] STACK_STEP   = 32'h0000_0004;

   // ************************************************************
   // exception numbers
   // ************************************************************
   localparam logic [5:0] EXC_THREAD    = 6'h00;
   localparam logic [5:0] EXC_NMI       = 6'h02;
   localparam logic [5:0] EXC_HARD      = 6'h03;
   localparam logic [5:0] EXC_SUP_CALL  = 6'h0b;
   localparam logic [5:0] EXC_PEND_SERV = 6'h0e;
   localparam logic [5:0] EXC_TICK      = 6'h0f;
   localparam logic [5:0] EXC_EXT_FIRST = 6'h10;
   localparam logic [5:0] EXC_EXT_LAST  = 6'h2f;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      CMPR_BOOT_SP = 2'b00,
      CMPR_BOOT_PC = 2'b01,
      CMPR_RUN     = 2'b10
   } cmpr_boot_t;

   typedef struct packed {
      logic        we;
      logic [3:0]  sel;
      logic [31:0] data;
   } cmpr_spr_wr_t;

   typedef struct packed {
      logic        we;
      logic [3:0]  idx;
      logic [31:0] data;
   } cmpr_core_wr_t;

   typedef struct packed {
      logic [3:0] flags;
      logic [5:0] exc_num;
      logic       exec_t;
   } cmpr_psw_t;

endpackage

// ===== cmpr_gpr_file.sv
`timescale 1ns/10ps
module cmpr_gpr_file #(
   parameter int unsigned N = 13,
   parameter int unsigned W = 32
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // write port
   input  wire logic              we,
   input  wire logic [3:0]        widx,
   input  wire logic [W-1:0]      wdata,
   // read port
   input  wire logic [3:0]        ridx,
   output      logic [W-1:0]      rdata
);

   // no reset value
   // contents undefined until written, saves reset fan-out
   logic [W-1:0] mem_ff [N];

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_reg
         always_ff @(posedge clk)
         begin
            if (we && widx == 4'(g))
               mem_ff[g] <= wdata;
         end
      end
   endgenerate

   always_comb
   begin
      rdata = '0;
      if (ridx < 4'(N))
         rdata = mem_ff[ridx];
   end

endmodule

// ===== cmpr_core_regs.sv
`timescale 1ns/10ps
module cmpr_core_regs (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // reset vector fetch
   output      logic                   vec_req,
   output      logic [31:0]            vec_addr,
   input  wire logic                   vec_valid,
   input  wire logic [31:0]            vec_data,
   // core register port
   input  wire cmpr_pkg::cmpr_core_wr_t core_wr,
   input  wire logic [3:0]             core_ridx,
   output      logic [31:0]            core_rdata,
   // stack push
   input  wire logic                   push,
   output      logic [31:0]            push_addr,
   // special register moves
   input  wire cmpr_pkg::cmpr_spr_wr_t spr_wr,
   input  wire logic [3:0]             spr_rsel,
   output      logic [31:0]            spr_rdata,
   // flags from the execution unit
   input  wire logic                   flags_we,
   input  wire logic [3:0]             flags_in,
   // exception sequencing
   input  wire logic                   exc_enter,
   input  wire logic [5:0]             exc_num_in,
   input  wire logic                   exc_all_done,
   input  wire logic                   exec_t_we,
   input  wire logic                   exec_t_in,
   // processor state requests
   input  wire logic                   mask_set_req,
   input  wire logic                   mask_clr_req,
   input  wire logic                   sys_access_req,
   input  wire logic                   sup_call_exec,
   // status outputs
   output      logic                   handler_mode,
   output      logic                   privileged,
   output      logic                   use_proc_sp,
   output      logic                   sys_access_ok,
   output      logic                   sup_call_take,
   output      logic                   cfg_exc_blocked,
   output      logic                   core_running
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      cmpr_pkg::cmpr_boot_t boot;
      logic [31:0]          main_sp;
      logic [31:0]          proc_sp;
      logic [31:0]          link;
      logic [31:0]          pc;
      cmpr_pkg::cmpr_psw_t  psw;
      logic                 prio_mask;
      logic [1:0]           mode_ctrl;
   } cmpr_state_t;

   cmpr_state_t state_ff;
   cmpr_state_t nxt_state;

   logic        in_handler;
   logic        is_priv;
   logic        sel_proc;
   logic [31:0] active_sp;
   logic [31:0] psw_word;
   logic [31:0] gpr_rdata;
   logic        gpr_we;

   // ************************************************************
   // mode, privilege and stack selection
   // ************************************************************
   // exception number nonzero means handler mode
   always_comb
   begin
      in_handler = (state_ff.psw.exc_num != cmpr_pkg::EXC_THREAD);
      is_priv = in_handler ||
                !state_ff.mode_ctrl[cmpr_pkg::CTRL_PRIV_BIT];
      sel_proc = !in_handler &&
                 state_ff.mode_ctrl[cmpr_pkg::CTRL_STACK_BIT];
      active_sp = sel_proc ? state_ff.proc_sp : state_ff.main_sp;
      psw_word = '0;
      psw_word[cmpr_pkg::FLAG_N_BIT -: 4] = state_ff.psw.flags;
      psw_word[5:0] = state_ff.psw.exc_num;
      psw_word[cmpr_pkg::EXEC_T_BIT] = state_ff.psw.exec_t;
   end

   assign handler_mode    = in_handler;
   assign privileged      = is_priv;
   assign use_proc_sp     = sel_proc;
   assign core_running    = (state_ff.boot == cmpr_pkg::CMPR_RUN);
   assign sys_access_ok   = sys_access_req && is_priv;
   assign sup_call_take   = sup_call_exec && core_running;
   assign cfg_exc_blocked = state_ff.prio_mask;
   assign vec_req         = !core_running;
   assign vec_addr = (state_ff.boot == cmpr_pkg::CMPR_BOOT_SP) ?
                     cmpr_pkg::VEC_SP_ADDR : cmpr_pkg::VEC_PC_ADDR;
   assign push_addr = active_sp - cmpr_pkg::STACK_STEP;

   // ************************************************************
   // general purpose registers
   // ************************************************************
   // thirteen data registers
   assign gpr_we = core_running && core_wr.we &&
                   core_wr.idx < cmpr_pkg::REG_SP;

   cmpr_gpr_file #(
      .N (cmpr_pkg::NUM_GPR),
      .W (cmpr_pkg::DATA_W)
   ) u_gpr (
      .clk   (clk),
      .nrst  (nrst),
      .we    (gpr_we),
      .widx  (core_wr.idx),
      .wdata (core_wr.data),
      .ridx  (core_ridx),
      .rdata (gpr_rdata)
   );

   // ************************************************************
   // read paths
   // ************************************************************
   always_comb
   begin
      case (core_ridx)
         cmpr_pkg::REG_SP: core_rdata = active_sp;
         cmpr_pkg::REG_LR: core_rdata = state_ff.link;
         cmpr_pkg::REG_PC: core_rdata = state_ff.pc;
         default:          core_rdata = gpr_rdata;
      endcase
   end

   always_comb
   begin
      spr_rdata = '0;
      case (spr_rsel)
         cmpr_pkg::SPR_FLAGS, cmpr_pkg::SPR_FLAGS_EXEC:
            spr_rdata[31:28] = psw_word[31:28];
         cmpr_pkg::SPR_FLAGS_EXC, cmpr_pkg::SPR_PSW:
         begin
            spr_rdata[31:28] = psw_word[31:28];
            spr_rdata[5:0]   = psw_word[5:0];
         end
         cmpr_pkg::SPR_EXC, cmpr_pkg::SPR_EXEC_EXC:
            spr_rdata[5:0] = psw_word[5:0];
         cmpr_pkg::SPR_MAIN_SP:   spr_rdata = state_ff.main_sp;
         cmpr_pkg::SPR_PROC_SP:   spr_rdata = state_ff.proc_sp;
         cmpr_pkg::SPR_PRIO_MASK:
            spr_rdata[cmpr_pkg::PMASK_BIT] = state_ff.prio_mask;
         cmpr_pkg::SPR_MODE_CTRL:
         begin
            spr_rdata[cmpr_pkg::CTRL_PRIV_BIT] =
               state_ff.mode_ctrl[cmpr_pkg::CTRL_PRIV_BIT];
            // stack bit reads zero in handler
            spr_rdata[cmpr_pkg::CTRL_STACK_BIT] = sel_proc;
         end
         default: spr_rdata = '0;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff.boot)
         cmpr_pkg::CMPR_BOOT_SP:
            if (vec_valid)
            begin
               nxt_state.main_sp = vec_data;
               nxt_state.boot    = cmpr_pkg::CMPR_BOOT_PC;
            end
         cmpr_pkg::CMPR_BOOT_PC:
            if (vec_valid)
            begin
               // pc and exec bit from vector
               nxt_state.pc          = vec_data;
               nxt_state.psw.exec_t  = vec_data[0];
               nxt_state.boot        = cmpr_pkg::CMPR_RUN;
            end
         cmpr_pkg::CMPR_RUN:
         begin
            if (core_wr.we)
            begin
               case (core_wr.idx)
                  cmpr_pkg::REG_SP:
                     if (sel_proc)
                        nxt_state.proc_sp = core_wr.data;
                     else
                        nxt_state.main_sp = core_wr.data;
                  cmpr_pkg::REG_LR: nxt_state.link = core_wr.data;
                  cmpr_pkg::REG_PC: nxt_state.pc   = core_wr.data;
                  default:          nxt_state.link = state_ff.link;
               endcase
            end
            if (push)
            begin
               if (sel_proc)
                  nxt_state.proc_sp = push_addr;
               else
                  nxt_state.main_sp = push_addr;
            end
            if (flags_we)
               nxt_state.psw.flags = flags_in;
            if (spr_wr.we)
            begin
               // exception and exec bits not written by moves
               case (spr_wr.sel)
                  cmpr_pkg::SPR_FLAGS, cmpr_pkg::SPR_FLAGS_EXC,
                  cmpr_pkg::SPR_FLAGS_EXEC, cmpr_pkg::SPR_PSW:
                     nxt_state.psw.flags = spr_wr.data[31:28];
                  cmpr_pkg::SPR_MAIN_SP:
                     if (is_priv)
                        nxt_state.main_sp = spr_wr.data;
                  cmpr_pkg::SPR_PROC_SP:
                     if (is_priv)
                        nxt_state.proc_sp = spr_wr.data;
                  cmpr_pkg::SPR_PRIO_MASK:
                     if (is_priv)
                        nxt_state.prio_mask =
                           spr_wr.data[cmpr_pkg::PMASK_BIT];
                  cmpr_pkg::SPR_MODE_CTRL:
                     if (is_priv)
                     begin
                        nxt_state.mode_ctrl[cmpr_pkg::CTRL_PRIV_BIT] =
                           spr_wr.data[cmpr_pkg::CTRL_PRIV_BIT];
                        if (!in_handler)
                           nxt_state.mode_ctrl[cmpr_pkg::CTRL_STACK_BIT] =
                              spr_wr.data[cmpr_pkg::CTRL_STACK_BIT];
                     end
                  default: nxt_state.prio_mask = state_ff.prio_mask;
               endcase
            end
            if (is_priv && mask_set_req)
               nxt_state.prio_mask = 1'b1;
            else if (is_priv && mask_clr_req)
               nxt_state.prio_mask = 1'b0;
            if (exec_t_we)
               nxt_state.psw.exec_t = exec_t_in;
            if (exc_enter)
               nxt_state.psw.exc_num = exc_num_in;
            // back to thread after all processing
            else if (exc_all_done && in_handler)
               nxt_state.psw.exc_num = cmpr_pkg::EXC_THREAD;
         end
         default: nxt_state.boot = cmpr_pkg::CMPR_BOOT_SP;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff           <= '0;
         state_ff.boot      <= cmpr_pkg::CMPR_BOOT_SP;
         state_ff.psw       <= '0;
         state_ff.prio_mask <= cmpr_pkg::PMASK_RESET;
         state_ff.mode_ctrl <= cmpr_pkg::CTRL_RESET;
      end
      else
         state_ff <= nxt_state;
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_handler_priv: assert property (@(posedge clk) disable iff (!nrst)
      in_handler |-> privileged)
      else $error("handler mode not privileged");
   a_handler_main: assert property (@(posedge clk) disable iff (!nrst)
      in_handler |-> !use_proc_sp)
      else $error("handler mode selects process stack");
   a_unpriv_ctrl: assert property (@(posedge clk) disable iff (!nrst)
      (core_running && !is_priv && spr_wr.we &&
       spr_wr.sel == cmpr_pkg::SPR_MODE_CTRL && !exc_enter)
      |=> $stable(state_ff.mode_ctrl))
      else $error("unprivileged control write took effect");
   a_push_desc: assert property (@(posedge clk) disable iff (!nrst)
      (core_running && push && !sel_proc && !core_wr.we && !spr_wr.we
       && !exc_enter)
      |=> state_ff.main_sp == $past(state_ff.main_sp) - 32'h4)
      else $error("push did not decrement stack pointer");
   a_exc_wr_ign: assert property (@(posedge clk) disable iff (!nrst)
      (core_running && !exc_enter && !exc_all_done)
      |=> $stable(state_ff.psw.exc_num))
      else $error("exception number changed without sequencing");
   a_exec_reads0: assert property (@(posedge clk) disable iff (!nrst)
      spr_rdata[24] == 1'b0)
      else $error("exec state bit visible to software");
   a_boot_pc: assert property (@(posedge clk) disable iff (!nrst)
      (state_ff.boot == cmpr_pkg::CMPR_BOOT_PC && vec_valid)
      |=> state_ff.pc == $past(vec_data) &&
          state_ff.psw.exec_t == $past(vec_data[0]))
      else $error("reset vector not loaded");
   a_boot_sp: assert property (@(posedge clk) disable iff (!nrst)
      (state_ff.boot == cmpr_pkg::CMPR_BOOT_SP && vec_valid)
      |=> state_ff.main_sp == $past(vec_data))
      else $error("main stack pointer not loaded");
   a_return_thr: assert property (@(posedge clk) disable iff (!nrst)
      (core_running && in_handler && exc_all_done && !exc_enter)
      |=> !in_handler)
      else $error("no return to thread mode");
   a_mask_unpriv: assert property (@(posedge clk) disable iff (!nrst)
      (core_running && !is_priv && mask_set_req && !spr_wr.we)
      |=> $stable(state_ff.prio_mask))
      else $error("unprivileged mask change");

   c_boot_done: cover property (@(posedge clk) disable iff (!nrst)
      $rose(core_running));
   c_enter_exc: cover property (@(posedge clk) disable iff (!nrst)
      !in_handler ##1 in_handler ##[1:20] !in_handler);
   c_proc_sp: cover property (@(posedge clk) disable iff (!nrst)
      use_proc_sp && push);
   c_unpriv: cover property (@(posedge clk) disable iff (!nrst)
      !privileged && sup_call_take);

endmodule

// ===== cmpr_core_regs_test.sv
`timescale 1ns/10ps
module cmpr_core_regs_test;
   logic                   clk, nrst, vec_req, vec_valid, push, flags_we;
   logic                   exc_enter, exc_all_done, exec_t_we, exec_t_in;
   logic                   mask_set_req, mask_clr_req, sys_access_req;
   logic                   sup_call_exec, handler_mode, privileged;
   logic                   sys_access_ok, sup_call_take, cfg_exc_blocked;
   logic                   core_running, use_proc_sp;
   logic [31:0]            vec_addr, vec_data, core_rdata, push_addr;
   logic [31:0]            spr_rdata;
   logic [3:0]             core_ridx, spr_rsel, flags_in;
   logic [5:0]             exc_num_in;
   cmpr_pkg::cmpr_core_wr_t core_wr;
   cmpr_pkg::cmpr_spr_wr_t  spr_wr;
   int                     errors, checks_done;

   cmpr_core_regs u_dut (.clk(clk), .nrst(nrst), .vec_req(vec_req),
      .vec_addr(vec_addr), .vec_valid(vec_valid), .vec_data(vec_data),
      .core_wr(core_wr), .core_ridx(core_ridx), .core_rdata(core_rdata),
      .push(push), .push_addr(push_addr), .spr_wr(spr_wr),
      .spr_rsel(spr_rsel), .spr_rdata(spr_rdata), .flags_we(flags_we),
      .flags_in(flags_in), .exc_enter(exc_enter), .exc_num_in(exc_num_in),
      .exc_all_done(exc_all_done), .exec_t_we(exec_t_we),
      .exec_t_in(exec_t_in), .mask_set_req(mask_set_req),
      .mask_clr_req(mask_clr_req), .sys_access_req(sys_access_req),
      .sup_call_exec(sup_call_exec), .handler_mode(handler_mode),
      .privileged(privileged), .use_proc_sp(use_proc_sp),
      .sys_access_ok(sys_access_ok), .sup_call_take(sup_call_take),
      .cfg_exc_blocked(cfg_exc_blocked), .core_running(core_running));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic finish_test();
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // inputs change one small delay after the rising edge
   task automatic cyc();
      @(posedge clk);
      #1;
   endtask

   task automatic rd_spr(input logic [3:0] sel, input logic [31:0] exp);
      spr_rsel = sel;
      #1;
      chk(spr_rdata, exp);
   endtask

   task automatic rd_core(input logic [3:0] idx, input logic [31:0] exp);
      core_ridx = idx;
      #1;
      chk(core_rdata, exp);
   endtask

   task automatic spr_w(input logic [3:0] sel, input logic [31:0] d);
      spr_wr = '{we: 1'b1, sel: sel, data: d};
      cyc();
      spr_wr.we = 1'b0;
   endtask

   task automatic exc_pulse(input logic enter, input logic [5:0] num);
      exc_num_in = num;
      exc_enter = enter;
      exc_all_done = ~enter;
      cyc();
      exc_enter = 1'b0;
      exc_all_done = 1'b0;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic boot_check();
      chkb(vec_req, 1'b1);
      chk(vec_addr, cmpr_pkg::VEC_SP_ADDR);
      vec_valid = 1'b1;
      vec_data = 32'h2000_1000;
      cyc();
      chk(vec_addr, cmpr_pkg::VEC_PC_ADDR);
      vec_data = 32'h0000_0101;
      cyc();
      vec_valid = 1'b0;
      vec_data = 32'hdfff_fefe;
      for (int n = 0; n < 8 && core_running !== 1'b1; n++)
         cyc();
      if (core_running !== 1'b1)
      begin
         chkb(core_running, 1'b1);
         finish_test();
      end
      chkb(handler_mode, 1'b0);
      rd_spr(cmpr_pkg::SPR_EXC, 32'h0);
      rd_spr(cmpr_pkg::SPR_PRIO_MASK, 32'h0);
      rd_spr(cmpr_pkg::SPR_MODE_CTRL, 32'h0);
      rd_spr(cmpr_pkg::SPR_MAIN_SP, 32'h2000_1000);
      core_ridx = cmpr_pkg::REG_PC;
      #1;
      chk(core_rdata & 32'hffff_fffe, 32'h0000_0100);
      rd_spr(cmpr_pkg::SPR_EXEC, 32'h0);
   endtask

   task automatic gpr_check();
      for (int i = 0; i < 16; i++)
      begin
         if (i == 13)
            continue;
         core_wr = '{we: 1'b1, idx: 4'(i), data: {28'h5a3c_96e, 4'(i)}};
         cyc();
      end
      core_wr.we = 1'b0;
      for (int i = 0; i < 16; i++)
         if (i != 13)
            rd_core(4'(i), {28'h5a3c_96e, 4'(i)});
      rd_core(cmpr_pkg::REG_SP, 32'h2000_1000);
      chk(push_addr, 32'h2000_0ffc);
      push = 1'b1;
      cyc();
      push = 1'b0;
      rd_spr(cmpr_pkg::SPR_MAIN_SP, 32'h2000_0ffc);
   endtask

   task automatic flags_check();
      flags_in = 4'ha;
      flags_we = 1'b1;
      cyc();
      flags_we = 1'b0;
      rd_spr(cmpr_pkg::SPR_FLAGS, 32'ha000_0000);
      rd_spr(cmpr_pkg::SPR_PSW, 32'ha000_0000);
      rd_spr(cmpr_pkg::SPR_EXEC_EXC, 32'h0);
      spr_w(cmpr_pkg::SPR_PSW, 32'h5100_003f);
      rd_spr(cmpr_pkg::SPR_PSW, 32'h5000_0000);
      spr_w(cmpr_pkg::SPR_FLAGS_EXC, 32'h3000_0005);
      rd_spr(cmpr_pkg::SPR_FLAGS_EXC, 32'h3000_0000);
      spr_w(cmpr_pkg::SPR_FLAGS_EXEC, 32'hc100_0000);
      rd_spr(cmpr_pkg::SPR_FLAGS_EXEC, 32'hc000_0000);
      spr_w(cmpr_pkg::SPR_FLAGS, 32'h9fff_ffff);
      rd_spr(cmpr_pkg::SPR_FLAGS, 32'h9000_0000);
   endtask

   task automatic exc_check();
      logic [5:0] codes [7];
      codes = '{cmpr_pkg::EXC_NMI, cmpr_pkg::EXC_HARD, cmpr_pkg::EXC_SUP_CALL,
                cmpr_pkg::EXC_PEND_SERV, cmpr_pkg::EXC_TICK,
                cmpr_pkg::EXC_EXT_FIRST, cmpr_pkg::EXC_EXT_LAST};
      foreach (codes[k])
      begin
         cyc();
         exc_pulse(1'b1, codes[k]);
         spr_w(cmpr_pkg::SPR_EXC, 32'h0);
         chkb(handler_mode, 1'b1);
         rd_spr(cmpr_pkg::SPR_EXC, {26'h0, codes[k]});
         rd_spr(cmpr_pkg::SPR_FLAGS_EXC, {26'h240_0000, codes[k]});
         exc_pulse(1'b0, 6'h0);
         chkb(handler_mode, 1'b0);
      end
   endtask

   task automatic priv_check();
      spr_w(cmpr_pkg::SPR_PROC_SP, 32'h2000_0800);
      cyc();
      spr_w(cmpr_pkg::SPR_MODE_CTRL, 32'h3);
      chkb(privileged, 1'b0);
      chkb(use_proc_sp, 1'b1);
      rd_core(cmpr_pkg::REG_SP, 32'h2000_0800);
      chk(push_addr, 32'h2000_07fc);
      sys_access_req = 1'b1;
      sup_call_exec = 1'b1;
      mask_set_req = 1'b1;
      #1;
      chkb(sys_access_ok, 1'b0);
      chkb(sup_call_take, 1'b1);
      cyc();
      mask_set_req = 1'b0;
      sup_call_exec = 1'b0;
      chkb(cfg_exc_blocked, 1'b0);
      spr_w(cmpr_pkg::SPR_MODE_CTRL, 32'h0);
      rd_spr(cmpr_pkg::SPR_MODE_CTRL, 32'h3);
      exc_pulse(1'b1, cmpr_pkg::EXC_SUP_CALL);
      chkb(privileged, 1'b1);
      chkb(use_proc_sp, 1'b0);
      rd_core(cmpr_pkg::REG_SP, 32'h2000_0ffc);
      rd_spr(cmpr_pkg::SPR_MODE_CTRL, 32'h1);
      spr_w(cmpr_pkg::SPR_MODE_CTRL, 32'h0);
      exc_pulse(1'b0, 6'h0);
      rd_spr(cmpr_pkg::SPR_MODE_CTRL, 32'h2);
      chkb(sys_access_ok, 1'b1);
      sys_access_req = 1'b0;
      spr_w(cmpr_pkg::SPR_MODE_CTRL, 32'h0);
      chkb(use_proc_sp, 1'b0);
   endtask

   task automatic mask_check();
      mask_set_req = 1'b1;
      cyc();
      mask_set_req = 1'b0;
      chkb(cfg_exc_blocked, 1'b1);
      rd_spr(cmpr_pkg::SPR_PRIO_MASK, 32'h1);
      mask_clr_req = 1'b1;
      cyc();
      mask_clr_req = 1'b0;
      chkb(cfg_exc_blocked, 1'b0);
      spr_w(cmpr_pkg::SPR_PRIO_MASK, 32'h1);
      chkb(cfg_exc_blocked, 1'b1);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      {nrst, vec_valid, push, flags_we, exc_enter, exc_all_done} = '0;
      {exec_t_we, exec_t_in, mask_set_req, mask_clr_req} = '0;
      {sys_access_req, sup_call_exec, flags_in, exc_num_in} = '0;
      {vec_data, core_ridx, spr_rsel} = '0;
      core_wr = '0;
      spr_wr = '0;
      errors = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      #1;
      nrst = 1'b1;
      boot_check();
      gpr_check();
      flags_check();
      exc_check();
      priv_check();
      mask_check();
      finish_test();
   end
endmodule
